// File: rtl/wwdt_regs.vh
// constants for the windowed watchdog timer
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

// apb byte offsets
`define WWDT_OFS_KICK 8'h00
`define WWDT_OFS_STATUS 8'h04
`define WWDT_OFS_CAUSE 8'h08
`define WWDT_OFS_OPTION 8'h0c

// kick register key and read-back values
`define WWDT_KEY 8'hac
`define WWDT_KICK_RD_ON 8'h9a
`define WWDT_KICK_RD_OFF 8'h1a

// option byte fields
`define WWDT_OPT_IRQ 7
`define WWDT_OPT_WIN_HI 6
`define WWDT_OPT_WIN_LO 5
`define WWDT_OPT_EN 4
`define WWDT_OPT_OVF_HI 3
`define WWDT_OPT_OVF_LO 1
`define WWDT_OPT_STBY 0
`define WWDT_OPT_RESET 8'h00

// overflow select codes
`define WWDT_OVF_SEL_6 3'h0
`define WWDT_OVF_SEL_7 3'h1
`define WWDT_OVF_SEL_8 3'h2
`define WWDT_OVF_SEL_9 3'h3
`define WWDT_OVF_SEL_11 3'h4

// overflow limits in half low-speed periods (2 x 2^n)
`define WWDT_OVF_HALF_6 17'h00080
`define WWDT_OVF_HALF_7 17'h00100
`define WWDT_OVF_HALF_8 17'h00200
`define WWDT_OVF_HALF_9 17'h00400
`define WWDT_OVF_HALF_11 17'h01000

// window select codes
`define WWDT_WIN_50 2'h1
`define WWDT_WIN_75 2'h2
`define WWDT_WIN_100 2'h3

// status register fields
`define WWDT_ST_CNT_HI 16
`define WWDT_ST_OPEN 17
`define WWDT_ST_FIRST 18
`define WWDT_ST_RUN 19

// reset cause flag position
`define WWDT_CAUSE_BIT 4

// timing: system clock and low-speed oscillator, in hertz
`define WWDT_CLK_HZ 40000000
`define WWDT_FIL_HZ 15000
// half-period divider, rounded down
`define WWDT_HALF_DIV (`WWDT_CLK_HZ / (2 * `WWDT_FIL_HZ))
`define WWDT_DIV_W 12
// last divider count: WWDT_HALF_DIV - 1 at the divider width
`define WWDT_HALF_LAST 12'h534

`endif

// File: rtl/wwdt_tick.v
// half low-speed period enable generator
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module wwdt_tick (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire restart,
    output reg halfTick
);

localparam [`WWDT_DIV_W-1:0] DIV_LAST = `WWDT_HALF_LAST;

reg [`WWDT_DIV_W-1:0] div_r;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        div_r <= {`WWDT_DIV_W{1'b0}};
        halfTick <= 1'b0;
    end else if (restart || !run) begin
        div_r <= {`WWDT_DIV_W{1'b0}};
        halfTick <= 1'b0;
    end else if (div_r == DIV_LAST) begin
        div_r <= {`WWDT_DIV_W{1'b0}};
        halfTick <= 1'b1;
    end else begin
        div_r <= div_r + 1'b1;
        halfTick <= 1'b0;
    end
end

endmodule // wwdt_tick

// File: rtl/wwdt_top.v
// windowed watchdog timer with apb register access
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "wwdt_regs.vh"

// Operation
// R1: with count enable set, counting starts right after reset release.
// R2: with count enable clear, counter stays stopped and never overflows.
// R3: writing key ACH before overflow clears counter and restarts from zero.
// R4: after the first kick, a write in the closed window raises reset.
// R5: reaching overflow without a valid key raises internal reset.
// R6: a single-bit access to the kick register raises internal reset.
// R7: writing any value other than ACH raises internal reset.
// R8: first kick after reset clears counter anytime, window not checked.
// R9: a valid kick clears the counter within two low-speed clocks.
// R10: a kick on the last count before overflow still clears.
// R11: standby-run 0 stops counting in standby; 1 keeps counting.
// R12: standby-run 0: leaving standby clears counter and restarts.
// R13: overflow select picks 2^6, 2^7, 2^8, 2^9 or 2^11 periods.
// R14: window select 01, 10, 11 gives 50, 75, 100 percent open.
// R15: closed window is the first part; open runs until overflow.
// R16: standby-run 0 forces the open window to 100 percent.
// R17: interval irq at 75 percent plus half a period when enabled.
// R18: interval irq leaves counting alone; overflow still resets.
// R19: every watchdog reset sets the reset cause flag, bit 4.
// R20: kick register reads 9AH when enabled, 1AH when disabled.
// R21: counter runs on the low-speed oscillator clock rate.
module wwdt_top (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire bitOpAccess,
    input wire [7:0] optionByte,
    input wire standbyMode,
    output reg internalReset,
    output reg intervalIrq,
    output reg watchdogResetCauseFlag
);

// one-hot control states
localparam [2:0] ST_LOAD = 3'b001;
localparam [2:0] ST_RUN = 3'b010;
localparam [2:0] ST_OFF = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [7:0] option_r;
reg [16:0] cnt_r;
reg [16:0] cnt_nxt;
reg firstKick_r;
reg kickPend_r;
reg stbyPrev_r;
reg [16:0] ovfHalf;
reg [16:0] closeEnd;
wire [16:0] irqAt;
wire [2:0] ovfSel;
wire [1:0] winSel;
wire countEnable;
wire standbyRun;
wire running;
wire halfTick;
wire accessPhase;
wire setupPhase;
wire kickWrite;
wire causeWrite;
wire addrHit;
wire windowOpen;
wire keyFault;
wire bitFault;
wire closedFault;
wire kickFault;
wire overflow;
wire leaveStandby;
wire restartCnt;
wire faultReq;
wire irqHit;
wire tickStep;
wire kickAddr;
reg [31:0] rdData_nxt;

assign ovfSel = option_r[`WWDT_OPT_OVF_HI:`WWDT_OPT_OVF_LO];
assign winSel = {option_r[`WWDT_OPT_WIN_HI], option_r[`WWDT_OPT_WIN_LO]};
assign countEnable = option_r[`WWDT_OPT_EN];
assign standbyRun = option_r[`WWDT_OPT_STBY];

// R13 overflow count select
always @* begin
    case (ovfSel)
        `WWDT_OVF_SEL_6: ovfHalf = `WWDT_OVF_HALF_6;
        `WWDT_OVF_SEL_7: ovfHalf = `WWDT_OVF_HALF_7;
        `WWDT_OVF_SEL_8: ovfHalf = `WWDT_OVF_HALF_8;
        `WWDT_OVF_SEL_9: ovfHalf = `WWDT_OVF_HALF_9;
        `WWDT_OVF_SEL_11: ovfHalf = `WWDT_OVF_HALF_11;
        // prohibited codes act as the longest time
        default: ovfHalf = `WWDT_OVF_HALF_11;
    endcase
end

// R14 R15 R16 closed part of the period
always @* begin
    if (!standbyRun) begin
        closeEnd = 17'h00000;
    end else begin
        case (winSel)
            `WWDT_WIN_50: closeEnd = ovfHalf >> 1;
            `WWDT_WIN_75: closeEnd = ovfHalf >> 2;
            `WWDT_WIN_100: closeEnd = 17'h00000;
            // prohibited code 00 acts as fully open
            default: closeEnd = 17'h00000;
        endcase
    end
end

// R17 75 percent plus half a low-speed period
// counts are half periods, so plus one is the extra half period
assign irqAt = (ovfHalf >> 1) + (ovfHalf >> 2) + 17'h00001;

// R15 window open from closeEnd up to overflow
assign windowOpen = (cnt_r >= closeEnd);

// R11 counting gated by standby mode
assign running = (state_r == ST_RUN) && (!standbyMode || standbyRun);

// one count step per low-speed half period
assign tickStep = running && halfTick;

// R12 leaving standby without standby-run restarts
// fires once, on the cycle after standby ends
assign leaveStandby = stbyPrev_r && !standbyMode && !standbyRun;

// apb decode, zero wait states
assign pready = 1'b1;
assign setupPhase = psel && !penable;
assign accessPhase = psel && penable;
assign addrHit = (paddr == `WWDT_OFS_KICK) || (paddr == `WWDT_OFS_STATUS) ||
                 (paddr == `WWDT_OFS_CAUSE) || (paddr == `WWDT_OFS_OPTION);
assign pslverr = accessPhase && !addrHit;
assign kickAddr = (paddr == `WWDT_OFS_KICK);
// kick writes are ignored while the counter is disabled
assign kickWrite = accessPhase && pwrite && kickAddr && pstrb[0] && (state_r == ST_RUN);
// the cause flag is cleared by writing a one
assign causeWrite = accessPhase && pwrite && (paddr == `WWDT_OFS_CAUSE) && pstrb[0];

// R6 single-bit access fault
assign bitFault = kickWrite && bitOpAccess;
// R7 wrong key fault
assign keyFault = kickWrite && (pwdata[7:0] != `WWDT_KEY);
// R4 R8 closed window checked only after first kick
assign closedFault = kickWrite && firstKick_r && !windowOpen;
assign kickFault = bitFault || keyFault || closedFault;

// R5 R10 overflow unless a pending kick lands on this tick;
// a kick taken on the overflow tick itself comes too late
assign overflow = tickStep && !kickPend_r && (cnt_r == ovfHalf - 17'h00001);

// any fault or overflow asks for a chip reset
assign faultReq = kickFault || overflow;

assign restartCnt = leaveStandby || faultReq;

// R21 low-speed clock rate as half-period enables
wwdt_tick wwdt_tick_i (
    .clk(clk),
    .rst_n(rst_n),
    .run(running),
    .restart(restartCnt),
    .halfTick(halfTick)
);

// control state
always @* begin
    case (state_r)
        ST_LOAD: begin
            // R1 R2 start or stay stopped per option
            if (optionByte[`WWDT_OPT_EN]) begin
                state_nxt = ST_RUN;
            end else begin
                state_nxt = ST_OFF;
            end
        end
        ST_RUN: state_nxt = ST_RUN;
        ST_OFF: state_nxt = ST_OFF;
        default: state_nxt = ST_LOAD;
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_LOAD;
    end else begin
        state_r <= state_nxt;
    end
end

// option byte caught once after reset release; later changes wait for reset
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        option_r <= `WWDT_OPT_RESET;
    end else if (state_r == ST_LOAD) begin
        option_r <= optionByte;
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        stbyPrev_r <= 1'b0;
    end else begin
        stbyPrev_r <= standbyMode;
    end
end

// counter next value
always @* begin
    cnt_nxt = cnt_r;
    if (restartCnt) begin
        cnt_nxt = 17'h00000;
    end else if (running && halfTick) begin
        if (kickPend_r) begin
            // R3 R9 pending kick clears on next tick
            cnt_nxt = 17'h00000;
        end else begin
            cnt_nxt = cnt_r + 17'h00001;
        end
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_r <= 17'h00000;
    end else begin
        cnt_r <= cnt_nxt;
    end
end

// kick request held until the next half tick
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        kickPend_r <= 1'b0;
    end else if (restartCnt) begin
        kickPend_r <= 1'b0;
    end else if (kickWrite) begin
        // R3 valid key arms the clear
        kickPend_r <= 1'b1;
    end else if (tickStep) begin
        kickPend_r <= 1'b0;
    end
end

// a fault restarts the window sequence from the first kick
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        firstKick_r <= 1'b0;
    end else if (faultReq) begin
        firstKick_r <= 1'b0;
    end else if (kickWrite) begin
        // R8 later kicks see the window
        firstKick_r <= 1'b1;
    end
end

// R17 R18 irq point, counter untouched
assign irqHit = option_r[`WWDT_OPT_IRQ] && tickStep && !kickPend_r &&
                !restartCnt && (cnt_nxt == irqAt);

// R4 R5 R6 R7 internal reset request
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        internalReset <= 1'b0;
    end else begin
        internalReset <= faultReq;
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        intervalIrq <= 1'b0;
    end else begin
        intervalIrq <= irqHit;
    end
end

// R19 set wins over software clear
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        watchdogResetCauseFlag <= 1'b0;
    end else if (faultReq) begin
        watchdogResetCauseFlag <= 1'b1;
    end else if (causeWrite && pwdata[`WWDT_CAUSE_BIT]) begin
        watchdogResetCauseFlag <= 1'b0;
    end
end

// read data mux
always @* begin
    rdData_nxt = 32'h00000000;
    case (paddr)
        `WWDT_OFS_KICK: begin
            // R20 fixed read-back value
            if (countEnable) begin
                rdData_nxt[7:0] = `WWDT_KICK_RD_ON;
            end else begin
                rdData_nxt[7:0] = `WWDT_KICK_RD_OFF;
            end
        end
        `WWDT_OFS_STATUS: begin
            rdData_nxt[`WWDT_ST_CNT_HI:0] = cnt_r;
            rdData_nxt[`WWDT_ST_OPEN] = windowOpen;
            rdData_nxt[`WWDT_ST_FIRST] = firstKick_r;
            rdData_nxt[`WWDT_ST_RUN] = running;
        end
        `WWDT_OFS_CAUSE: begin
            rdData_nxt[`WWDT_CAUSE_BIT] = watchdogResetCauseFlag;
        end
        `WWDT_OFS_OPTION: begin
            rdData_nxt[7:0] = option_r;
        end
        default: begin
            rdData_nxt = 32'h00000000;
        end
    endcase
end

// read data captured in the setup cycle so it stands through the access phase
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        prdata <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
        prdata <= rdData_nxt;
    end
end

endmodule // wwdt_top

// File: testbench/wwdt_checker.sv
// port assertions for the windowed watchdog timer
`timescale 1ns/1ps
`include "wwdt_regs.vh"
module wwdt_checker (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire bitOpAccess,
    input wire [7:0] optionByte,
    input wire standbyMode,
    input wire internalReset,
    input wire intervalIrq,
    input wire watchdogResetCauseFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence kickWr;
        psel && penable && pwrite && paddr == `WWDT_OFS_KICK && pstrb[0]
            && optionByte[`WWDT_OPT_EN];
    endsequence
    sequence mapped;
        paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0c;
    endsequence
    a_wrong_key: assert property (kickWr ##0 (pwdata[7:0] != `WWDT_KEY && !bitOpAccess)
        |-> ##[1:2] internalReset) else $error("wrong key gave no reset");
    a_bitop_fault: assert property (kickWr ##0 bitOpAccess |-> ##[1:2] internalReset)
        else $error("bit access gave no reset");
    a_rst_pulse: assert property (internalReset |=> !internalReset)
        else $error("reset request too long");
    a_flag_set: assert property (internalReset |-> ##[0:1] watchdogResetCauseFlag)
        else $error("cause flag not set");
    a_no_rst_off: assert property (!optionByte[`WWDT_OPT_EN] |-> !internalReset)
        else $error("reset while disabled");
    a_irq_off: assert property (!optionByte[`WWDT_OPT_IRQ] |-> !intervalIrq)
        else $error("irq while not enabled");
    a_kick_read: assert property (psel && penable && !pwrite && paddr == `WWDT_OFS_KICK
        |-> prdata == {24'h0, optionByte[`WWDT_OPT_EN] ? 8'h9a : 8'h1a})
        else $error("kick read value wrong");
    a_err_unmap: assert property (psel && penable && !(paddr == 8'h00 || paddr == 8'h04
        || paddr == 8'h08 || paddr == 8'h0c) |-> pslverr) else $error("no slave error");
    a_err_quiet: assert property (psel && penable ##0 mapped |-> !pslverr)
        else $error("slave error on mapped address");
endmodule // wwdt_checker

bind wwdt_top wwdt_checker wwdt_checker_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .bitOpAccess, .optionByte, .standbyMode,
    .internalReset, .intervalIrq, .watchdogResetCauseFlag);

// File: testbench/tb_top.sv
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
`include "wwdt_regs.vh"
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, bitOpAccess, standbyMode;
    logic [7:0] paddr, optionByte;
    logic [31:0] pwdata, rd, st;
    logic [3:0] pstrb;
    wire pready, pslverr, internalReset, intervalIrq, watchdogResetCauseFlag;
    wire [31:0] prdata;
    int n_mismatch = 0;
    int total_checks = 0;
    int nRst = 0;
    int base;
    wwdt_top wwdt_top_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .bitOpAccess, .optionByte, .standbyMode, .internalReset,
        .intervalIrq, .watchdogResetCauseFlag);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (internalReset === 1'b1) nRst <= nRst + 1;
    end
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apbGo(input logic w, input logic [7:0] a, input logic [31:0] d, input logic b);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        bitOpAccess <= b;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        bitOpAccess <= 1'b0;
    endtask
    // kick write, then room for the reset request to show
    task kick(input logic [7:0] v, input logic b);
        apbGo(1'b1, `WWDT_OFS_KICK, {24'h0, v}, b);
        repeat (3) @(posedge clk);
    endtask
    task doRst(input logic [7:0] opt);
        rst_n <= 1'b0;
        optionByte <= opt;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        bitOpAccess = 1'b0;
        standbyMode = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        optionByte = 8'h00;
        doRst(8'h00);
        apbGo(1'b0, `WWDT_OFS_KICK, 32'h0, 1'b0);
        chk(rd, 32'h1a);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[`WWDT_ST_RUN], 1'b0);
        base = nRst;
        kick(8'h55, 1'b0);
        chk(nRst - base, 0);
        $display("test 1 done");
        doRst(8'h51);
        apbGo(1'b0, `WWDT_OFS_KICK, 32'h0, 1'b0);
        chk(rd, 32'h9a);
        apbGo(1'b0, `WWDT_OFS_OPTION, 32'h0, 1'b0);
        chk(rd, 32'h51);
        repeat (8000) @(posedge clk);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[16:0] > 17'h0, 1'b1);
        chk(rd[`WWDT_ST_OPEN], 1'b0);
        base = nRst;
        kick(8'hac, 1'b0);
        repeat (1400) @(posedge clk);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[16:0] <= 17'h2, 1'b1);
        chk(nRst - base, 0);
        kick(8'hac, 1'b0);
        chk(nRst - base, 1);
        apbGo(1'b0, `WWDT_OFS_CAUSE, 32'h0, 1'b0);
        chk(rd[`WWDT_CAUSE_BIT], 1'b1);
        apbGo(1'b1, `WWDT_OFS_CAUSE, 32'h10, 1'b0);
        apbGo(1'b0, `WWDT_OFS_CAUSE, 32'h0, 1'b0);
        chk(rd, 32'h0);
        apbGo(1'b0, 8'h10, 32'h0, 1'b0);
        chk(rd, 32'h0);
        // 75 percent open: closed for the first quarter of the period
        kick(8'hac, 1'b0);
        repeat (40000) @(posedge clk);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[`WWDT_ST_OPEN], 1'b0);
        repeat (6000) @(posedge clk);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[`WWDT_ST_OPEN], 1'b1);
        kick(8'hac, 1'b0);
        chk(nRst - base, 1);
        $display("test 2 done");
        doRst(8'h30);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[`WWDT_ST_OPEN], 1'b1);
        base = nRst;
        kick(8'hac, 1'b0);
        kick(8'hac, 1'b0);
        chk(nRst - base, 0);
        repeat (4000) @(posedge clk);
        standbyMode <= 1'b1;
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        st = rd;
        repeat (3000) @(posedge clk);
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[16:0], st[16:0]);
        standbyMode <= 1'b0;
        apbGo(1'b0, `WWDT_OFS_STATUS, 32'h0, 1'b0);
        chk(rd[16:0] <= 17'h1, 1'b1);
        $display("test 3 done");
        doRst(8'h11);
        base = nRst;
        kick(8'h55, 1'b0);
        chk(nRst - base, 1);
        kick(8'hac, 1'b1);
        chk(nRst - base, 2);
        $display("test 4 done");
        finish_test();
    end
endmodule // tb_top
